// ==== sim/dlim_assertions.sv ====
// Checker: timing relations on the byte lane link between both ends.
// Assumes: one lane; the controller makes link_clk from clk_sys_i.
module dlim_assertions (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  // Link signals
  input wire logic link_clk,
  input wire logic wr_cmd,
  input wire logic rd_cmd,
  input wire logic [7:0] ctl_dq,
  input wire logic ctl_oe,
  input wire logic [7:0] mem_dq,
  input wire logic [0:0] mem_flag_n,
  input wire logic mem_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_b_i);
  int unsigned oe_cnt;
  int unsigned next_oe_cnt;
  // Cycles the memory end has held the lane
  always_comb begin
    next_oe_cnt = mem_oe ? oe_cnt + 1 : 0;
  end
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) oe_cnt <= 0;
    else oe_cnt <= next_oe_cnt;
  end
  // ****
  // Lane rules
  // ****
  a_one_driver: assert property (!(ctl_oe && mem_oe))
    else $error("both ends drive the lane");
  a_cmd_apart: assert property (!(wr_cmd && rd_cmd))
    else $error("read and write command together");
  a_inv_few_zeros: assert property (mem_oe && !mem_flag_n[0] |-> $countones(mem_dq) >= 5)
    else $error("inverted read beat has too many zeros");
  a_link_half: assert property ($changed(link_clk) |=> $stable(link_clk) [*7])
    else $error("link clock half period too short");
  a_read_answer: assert property ($rose(rd_cmd) |-> ##[1:64] mem_oe)
    else $error("read burst did not start");
  a_eight_beats: assert property ($fell(mem_oe) |-> oe_cnt == 128)
    else $error("read burst not eight beats long");
  a_rd_beat_hold: assert property (mem_oe && $changed(mem_dq) |=>
    (!mem_oe || $stable(mem_dq)) [*8])
    else $error("read beat did not stand");
  a_wr_beat_hold: assert property (ctl_oe && $changed(ctl_dq) |=>
    (!ctl_oe || $stable(ctl_dq)) [*8])
    else $error("write beat did not stand");
  a_wr_drives: assert property ($rose(wr_cmd) |-> ##[0:48] ctl_oe)
    else $error("write burst did not start");
  // Main scenarios reached
  c_read: cover property ($rose(rd_cmd));
  c_write: cover property ($rose(wr_cmd));
  c_inverted: cover property (mem_oe && !mem_flag_n[0]);
endmodule

// ==== sim/dlim_tb.sv ====
// Bench: both lane ends joined; bursts run through the controller user side.
// Assumes: one byte lane, byte organisation, modes held steady per burst.
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_errors++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module dlim_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic wr_req = 1'b0, rd_req = 1'b0, use_inv = 1'b0, crc_ok = 1'b1, crc_en = 1'b0;
  logic [12:0] mr5 = 13'h0000;
  logic [11:0] mr1 = 12'h000;
  logic [3:0] addr = 4'h0;
  logic [63:0] wr_data = 64'h0000_0000_0000_0000;
  logic [7:0] wr_mask_n = 8'hff;
  logic busy, rd_valid, persist, done;
  logic [7:0] peek;
  logic [63:0] rd_data, exp;
  int n_errors = 0, tests_run = 0, cyc = 0, beats = 0, flag_lo = 0, n_done = 0;
  dlim_lane_if #(.LANES(1)) dlim_lane_if_i ();
  dlim_ctrl #(.LANES(1)) dlim_ctrl_i (.clk_sys_i, .rst_b_i, .lane(dlim_lane_if_i),
    .wr_req_i(wr_req), .rd_req_i(rd_req), .use_inv_i(use_inv), .crc_ok_i(crc_ok),
    .wr_data_i(wr_data), .wr_mask_n_i(wr_mask_n), .busy_o(busy), .rd_valid_o(rd_valid),
    .rd_data_o(rd_data));
  dlim_mem #(.ORG(dlim_pkg::ORG_X8), .LANES(1)) dlim_mem_i (.clk_sys_i, .rst_b_i,
    .lane(dlim_lane_if_i), .mode_register_five_i(mr5), .mode_register_one_i(mr1),
    .crc_en_i(crc_en), .addr_i(addr), .persistent_crc_o(persist), .wr_done_o(done),
    .peek_o(peek));
  dlim_assertions dlim_assertions_i (.clk_sys_i, .rst_b_i,
    .link_clk(dlim_lane_if_i.link_clk), .wr_cmd(dlim_lane_if_i.wr_cmd),
    .rd_cmd(dlim_lane_if_i.rd_cmd), .ctl_dq(dlim_lane_if_i.ctl_dq),
    .ctl_oe(dlim_lane_if_i.ctl_oe), .mem_dq(dlim_lane_if_i.mem_dq),
    .mem_flag_n(dlim_lane_if_i.mem_flag_n), .mem_oe(dlim_lane_if_i.mem_oe));
  // Clock, hang guard and commit count
  always #5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    cyc++;
    if (done === 1'b1) n_done++;
    if (cyc == 30000) begin
      n_errors++;
      report_and_stop();
    end
  end
  // Beats and low flags seen mid-beat on reads
  always @(negedge dlim_lane_if_i.link_clk) begin
    if (dlim_lane_if_i.mem_oe === 1'b1) begin
      beats++;
      if (dlim_lane_if_i.mem_flag_n[0] === 1'b0) flag_lo++;
    end
  end
  task automatic report_and_stop();
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Read data land with the first beat in the top byte
  function automatic logic [63:0] rev(input logic [63:0] d);
    for (int i = 0; i < 8; i++) rev[8*i+:8] = d[56-8*i+:8];
  endfunction
  // One burst; reads are array reads only, never pattern register reads
  task automatic go(input logic wr, input logic [3:0] a, input logic [63:0] d,
                    input logic [7:0] m);
    int n;
    logic seen;
    seen = 1'b0;
    beats = 0;
    flag_lo = 0;
    n_done = 0;
    @(posedge clk_sys_i);
    addr <= a;
    wr_data <= d;
    wr_mask_n <= m;
    wr_req <= wr;
    rd_req <= !wr;
    for (n = 0; n < 50 && busy !== 1'b1; n++) @(posedge clk_sys_i);
    wr_req <= 1'b0;
    rd_req <= 1'b0;
    for (n = 0; n < 3000 && (wr ? busy !== 1'b0 : !seen); n++) begin
      @(posedge clk_sys_i);
      if (!wr && rd_valid === 1'b1) begin
        seen = 1'b1;
        `CHK("read data", rev(exp), rd_data)
      end
    end
    if (!wr) `CHK("read done", 1'b1, seen)
    if (wr) `CHK("commit", 1, n_done)
    repeat (40) @(posedge clk_sys_i);
  endtask
  initial begin
    repeat (20) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    `CHK("flag idle", 1'b1, dlim_lane_if_i.mem_flag_n[0])
    `CHK("persist", 1'b0, persist)
    // Write and read inversion; 4 and 5 zero bytes on the boundary
    @(posedge clk_sys_i);
    mr5 <= 13'h1800;
    use_inv <= 1'b1;
    exp = 64'h807f_07fe_010f_ff00;
    go(1'b1, 4'h1, exp, 8'hff);
    `CHK("peek", exp[7:0], peek)
    go(1'b0, 4'h1, exp, 8'hff);
    `CHK("beats", 8, beats)
    `CHK("low flags", 4, flag_lo)
    // Read inversion off beside write inversion
    mr5 <= 13'h0800;
    go(1'b0, 4'h1, exp, 8'hff);
    `CHK("low flags off", 0, flag_lo)
    // Masking, one write mode only
    mr5 <= 13'h1400;
    use_inv <= 1'b0;
    go(1'b1, 4'h2, 64'h0123_4567_89ab_cdef, 8'hff);
    go(1'b1, 4'h2, 64'hffff_ffff_ffff_ffff, 8'h5a);
    exp = 64'h01ff_45ff_ffab_ffef;
    go(1'b0, 4'h2, exp, 8'hff);
    // Check failure without masking still writes
    mr5 <= 13'h1000;
    crc_en <= 1'b1;
    crc_ok <= 1'b0;
    exp = 64'h0123_4567_89ab_cdef;
    go(1'b1, 4'h3, exp, 8'hff);
    go(1'b0, 4'h3, exp, 8'hff);
    `CHK("nonpersist", 1'b0, persist)
    // Check failure with masking drops the burst
    mr5 <= 13'h0400;
    go(1'b1, 4'h3, 64'hffff_ffff_ffff_ffff, 8'hff);
    go(1'b0, 4'h3, exp, 8'hff);
    `CHK("persist set", 1'b1, persist)
    // Termination strobe on, every flag function off
    mr5 <= 13'h0000;
    mr1 <= 12'h800;
    go(1'b0, 4'h3, exp, 8'hff);
    `CHK("low flags term", 0, flag_lo)
    report_and_stop();
  end
endmodule

// ==== src/dlim_ctrl.sv ====
// Controller end: makes the link clock and runs write and read bursts.
// Assumes: memory end answers reads on the link clock edges after the command.
module dlim_ctrl #(
  parameter int LANES = 1
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  // Link side
  dlim_lane_if.ctrl lane,
  // User request
  input wire logic wr_req_i,
  input wire logic rd_req_i,
  input wire logic use_inv_i,
  input wire logic crc_ok_i,
  input wire logic [dlim_pkg::BEATS*LANES*8-1:0] wr_data_i,
  input wire logic [dlim_pkg::BEATS*LANES-1:0] wr_mask_n_i,
  // User answer
  output logic busy_o,
  output logic rd_valid_o,
  output logic [dlim_pkg::BEATS*LANES*8-1:0] rd_data_o
);
  localparam int BW = LANES * dlim_pkg::LANE_W;
  typedef enum logic [1:0] {DLIM_C_IDLE = 2'b00, DLIM_C_WR = 2'b01, DLIM_C_RD = 2'b10}
    dlim_cstate_e;
  // ****************************************
  // Link clock divider
  // ****************************************
  logic [dlim_pkg::DIV_W-1:0] div, next_div;
  logic lclk, next_lclk, fall;
  assign fall = lclk && div == dlim_pkg::DIV_W'(dlim_pkg::LINK_HALF_DIV - 1);
  always_comb begin
    next_div = (div == dlim_pkg::DIV_W'(dlim_pkg::LINK_HALF_DIV - 1)) ? '0 : div + 1'b1;
    next_lclk = (div == dlim_pkg::DIV_W'(dlim_pkg::LINK_HALF_DIV - 1)) ? ~lclk : lclk;
  end
  // ****************************************
  // Burst sequencer
  // ****************************************
  dlim_cstate_e state, next_state;
  logic [4:0] cnt, next_cnt;
  logic wr_c, next_wr_c, rd_c, next_rd_c, oe, next_oe, vld, next_vld;
  logic [BW-1:0] dq, next_dq;
  logic [LANES-1:0] fl, next_fl;
  logic [dlim_pkg::BEATS*BW-1:0] rdat, next_rdat;
  logic [dlim_pkg::BEATS*BW-1:0] wdat;
  logic [dlim_pkg::BEATS*LANES-1:0] wmsk;
  logic inv, next_inv;
  // Encode a write beat: inversion when chosen, else mask flag
  logic [BW-1:0] enc_dq;
  logic [LANES-1:0] enc_fl;
  logic [BW-1:0] dec_dq;
  logic [2:0] wbeat;
  assign wbeat = 3'(cnt - 5'h01);
  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_enc
      logic [7:0] b;
      assign b = wdat[(wbeat*LANES+g)*8 +: 8];
      // Send inverted when the byte has over four zeros
      assign enc_fl[g] = inv ? ($countones(b) >= (dlim_pkg::LANE_W - dlim_pkg::ZERO_LIMIT))
        : wmsk[wbeat*LANES+g];
      assign enc_dq[g*8 +: 8] = enc_fl[g] ? b : ~b;
      // Undo read inversion with this lane's own flag
      assign dec_dq[g*8 +: 8] = lane.mem_dq[g*8 +: 8] ^ {8{~lane.mem_flag_n[g]}};
    end
  endgenerate
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_wr_c = wr_c;
    next_rd_c = rd_c;
    next_oe = oe;
    next_dq = dq;
    next_fl = fl;
    next_rdat = rdat;
    next_vld = 1'b0;
    next_inv = inv;
    case (state)
      DLIM_C_IDLE: begin
        next_cnt = '0;
        if (wr_req_i) begin
          next_state = DLIM_C_WR;
          next_inv = use_inv_i;
        end else if (rd_req_i) begin
          next_state = DLIM_C_RD;
        end
      end
      DLIM_C_WR: begin
        if (fall) begin
          next_cnt = cnt + 1'b1;
          next_wr_c = (cnt == '0);
          next_oe = cnt != '0 && cnt <= 5'h08;
          next_dq = enc_dq;
          next_fl = enc_fl;
          if (cnt == 5'h0a) begin
            next_state = DLIM_C_IDLE;
            next_oe = 1'b0;
          end
        end
      end
      DLIM_C_RD: begin
        if (fall) begin
          next_cnt = cnt + 1'b1;
          next_rd_c = (cnt == '0);
          if (lane.mem_oe) begin
            next_rdat = {rdat[dlim_pkg::BEATS*BW-BW-1:0], dec_dq};
          end
          if (cnt == 5'h0e) begin
            next_vld = 1'b1;
            next_state = DLIM_C_IDLE;
          end
        end
      end
      default: next_state = DLIM_C_IDLE;
    endcase
  end
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      div <= '0;
      lclk <= 1'b0;
      state <= DLIM_C_IDLE;
      cnt <= '0;
      wr_c <= 1'b0;
      rd_c <= 1'b0;
      oe <= 1'b0;
      dq <= '0;
      fl <= '1;
      rdat <= '0;
      vld <= 1'b0;
      inv <= 1'b0;
      wdat <= '0;
      wmsk <= '1;
    end else begin
      div <= next_div;
      lclk <= next_lclk;
      state <= next_state;
      cnt <= next_cnt;
      wr_c <= next_wr_c;
      rd_c <= next_rd_c;
      oe <= next_oe;
      dq <= next_dq;
      fl <= next_fl;
      rdat <= next_rdat;
      vld <= next_vld;
      inv <= next_inv;
      if (state == DLIM_C_IDLE && wr_req_i) begin
        wdat <= wr_data_i;
        wmsk <= wr_mask_n_i;
      end
    end
  end
  assign lane.link_clk = lclk;
  assign lane.wr_cmd = wr_c;
  assign lane.rd_cmd = rd_c;
  assign lane.ctl_dq = dq;
  assign lane.ctl_flag_n = fl;
  assign lane.ctl_oe = oe;
  assign lane.crc_ok = crc_ok_i;
  assign busy_o = state != DLIM_C_IDLE;
  assign rd_valid_o = vld;
  assign rd_data_o = rdat;
endmodule

// ==== src/dlim_lane_if.sv ====
// Interface: the byte lane link between the controller and the memory end.
// Assumes: dual-role flag and data pins are carried as separate controller and memory drives.
interface dlim_lane_if #(
  parameter int LANES = 1
);
  // Link clock made by the controller
  logic link_clk;
  // Command strobes, one link cycle wide
  logic wr_cmd;
  logic rd_cmd;
  // Controller drive of data and flag
  logic [LANES*8-1:0] ctl_dq;
  logic [LANES-1:0] ctl_flag_n;
  logic ctl_oe;
  // Memory end drive of data and flag
  logic [LANES*8-1:0] mem_dq;
  logic [LANES-1:0] mem_flag_n;
  logic mem_oe;
  // Write check result supplied beside the burst
  logic crc_ok;

  modport ctrl (
    output link_clk, wr_cmd, rd_cmd, ctl_dq, ctl_flag_n, ctl_oe, crc_ok,
    input mem_dq, mem_flag_n, mem_oe
  );
  modport mem (
    input link_clk, wr_cmd, rd_cmd, ctl_dq, ctl_flag_n, ctl_oe, crc_ok,
    output mem_dq, mem_flag_n, mem_oe
  );
endinterface

// ==== src/dlim_mem.sv ====
// Memory end: receives write bursts with mask or inversion, answers read bursts.
// Assumes: the controller makes the link clock and never drives while we drive.
// Operation
// - Flag low on write: store inverted byte
// - Flag high on write: store byte unchanged
// - Four-bit organisation has no inversion, no masking
// - Read byte over four zeros: invert, flag low
// - Four or fewer zeros: plain, flag high
// - Eight beats, one byte and flag per lane
// - Masking never touches read data
// - Controller never enables masking with write inversion
// - Termination strobe needs masking and inversion off; the code turns only read inversion off when it is set
// - Read inversion free beside masking or write inversion
// - Mask flag low: byte discarded, array unchanged
// - Mask flag high: byte written
// - With CRC and masking, check before commit
// - Masked CRC mismatch: persistent, burst dropped
// - Unmasked CRC mismatch: burst still written
// - Controller avoids inversion on pattern register reads
//
// Our own choices: the register addresses and mode words taken as direct inputs.
module dlim_mem #(
  parameter int ORG = dlim_pkg::ORG_X8,
  parameter int LANES = 1,
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  // Link side
  dlim_lane_if.mem lane,
  // Mode words and address
  input wire logic [dlim_pkg::MR5_WIDTH-1:0] mode_register_five_i,
  input wire logic [dlim_pkg::MR1_WIDTH-1:0] mode_register_one_i,
  input wire logic crc_en_i,
  input wire logic [AW-1:0] addr_i,
  // Status
  output logic persistent_crc_o,
  output logic wr_done_o,
  output logic [LANES*8-1:0] peek_o
);
  localparam int LW = dlim_pkg::LANE_W;
  localparam logic HAS_FLAG = (ORG != dlim_pkg::ORG_X4);
  typedef enum logic [1:0] {DLIM_IDLE = 2'b00, DLIM_WR = 2'b01, DLIM_COMMIT = 2'b11,
    DLIM_RD = 2'b10} dlim_state_e;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic clk_s1, clk_s2;
  logic [LANES*8-1:0] dq_s1, dq_s2;
  logic [LANES-1:0] fl_s1, fl_s2;
  logic wr_s1, wr_s2, rd_s1, rd_s2, ok_s1, ok_s2, clk_d;
  // Two stages on every link input except ctl_oe, which is not used
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      clk_s1 <= '0;
      clk_s2 <= '0;
      dq_s1 <= '0;
      dq_s2 <= '0;
      fl_s1 <= '1;
      fl_s2 <= '1;
      wr_s1 <= 1'b0;
      wr_s2 <= 1'b0;
      rd_s1 <= 1'b0;
      rd_s2 <= 1'b0;
      ok_s1 <= 1'b1;
      ok_s2 <= 1'b1;
      clk_d <= 1'b0;
    end else begin
      clk_s1 <= lane.link_clk;
      clk_s2 <= clk_s1;
      dq_s1 <= lane.ctl_dq;
      dq_s2 <= dq_s1;
      fl_s1 <= lane.ctl_flag_n;
      fl_s2 <= fl_s1;
      wr_s1 <= lane.wr_cmd;
      wr_s2 <= wr_s1;
      rd_s1 <= lane.rd_cmd;
      rd_s2 <= rd_s1;
      ok_s1 <= lane.crc_ok;
      ok_s2 <= ok_s1;
      clk_d <= clk_s2;
    end
  end
  logic rise;
  assign rise = clk_s2 & ~clk_d;

  // ****************************************
  // Modes
  // ****************************************
  logic mask_en, winv_en, rinv_en;
  // Functions absent on the four-bit organisation
  assign mask_en = HAS_FLAG & mode_register_five_i[dlim_pkg::MASK_EN_BIT];
  // Masking wins if the controller breaks the exclusion
  assign winv_en = HAS_FLAG & mode_register_five_i[dlim_pkg::WINV_EN_BIT] & ~mask_en;
  // Termination strobe turns read inversion off when set; masking and write inversion keep the pin
  assign rinv_en = HAS_FLAG & mode_register_five_i[dlim_pkg::RINV_EN_BIT]
    & ~mode_register_one_i[dlim_pkg::TERM_EN_BIT];

  // ****************************************
  // Array and burst state
  // ****************************************
  logic [LW-1:0] mem [DEPTH][dlim_pkg::BEATS][LANES];
  logic [LW-1:0] stage [dlim_pkg::BEATS][LANES];
  logic [LANES-1:0] keep [dlim_pkg::BEATS];
  dlim_state_e state, next_state;
  logic [dlim_pkg::BEAT_W-1:0] beat, next_beat;
  logic persist, next_persist;
  logic [AW-1:0] adr, next_adr;
  logic [LANES*8-1:0] rd_dq, next_rd_dq;
  logic [LANES-1:0] rd_fl, next_rd_fl;
  logic oe, next_oe, done, next_done;

  // Per-lane write and read codecs
  logic [LANES*8-1:0] wr_byte, rd_byte_enc;
  logic [LANES-1:0] wr_keep, rd_flag_enc;
  logic [LANES*8-1:0] raw_rd;
  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      logic [3:0] zeros;
      // Flag low inverts, flag high passes
      assign wr_byte[g*LW +: LW] = (winv_en && !fl_s2[g]) ? ~dq_s2[g*LW +: LW]
        : dq_s2[g*LW +: LW];
      // Mask flag low discards, high
      assign wr_keep[g] = !mask_en || fl_s2[g];
      assign raw_rd[g*LW +: LW] = mem[adr][beat][g];
      // Zero count of this beat's byte only
      assign zeros = 4'(LW - $countones(raw_rd[g*LW +: LW]));
      // Over four zeros inverts and pulls flag low
      assign rd_flag_enc[g] = !(rinv_en && zeros > 4'(dlim_pkg::ZERO_LIMIT));
      assign rd_byte_enc[g*LW +: LW] = rd_flag_enc[g] ? raw_rd[g*LW +: LW]
        : ~raw_rd[g*LW +: LW];
    end
  endgenerate

  // Next-state of the burst sequencer
  always_comb begin
    next_state = state;
    next_beat = beat;
    next_persist = persist;
    next_adr = adr;
    next_rd_dq = rd_dq;
    next_rd_fl = rd_fl;
    next_oe = oe;
    next_done = 1'b0;
    case (state)
      DLIM_IDLE: begin
        next_beat = '0;
        if (rise && wr_s2) begin
          next_state = DLIM_WR;
          next_adr = addr_i;
        end else if (rise && rd_s2) begin
          next_state = DLIM_RD;
          next_adr = addr_i;
        end
      end
      DLIM_WR: begin
        if (rise) begin
          next_beat = beat + 1'b1;
          if (beat == dlim_pkg::LAST_BEAT) begin
            next_state = DLIM_COMMIT;
          end
        end
      end
      DLIM_COMMIT: begin
        // Masked mismatch latches persistent mode
        if (crc_en_i && mask_en && !ok_s2) begin
          next_persist = 1'b1;
        end
        next_done = 1'b1;
        next_state = DLIM_IDLE;
      end
      DLIM_RD: begin
        if (rise) begin
          // Read data never masked
          next_rd_dq = rd_byte_enc;
          next_rd_fl = rd_flag_enc;
          next_oe = 1'b1;
          next_beat = beat + 1'b1;
          if (oe && beat == '0) begin
            next_oe = 1'b0;
            next_state = DLIM_IDLE;
          end
        end
      end
      default: next_state = DLIM_IDLE;
    endcase
  end

  // Register the sequencer
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= DLIM_IDLE;
      beat <= '0;
      persist <= 1'b0;
      adr <= '0;
      rd_dq <= '0;
      rd_fl <= '1;
      oe <= 1'b0;
      done <= 1'b0;
    end else begin
      state <= next_state;
      beat <= next_beat;
      persist <= next_persist;
      adr <= next_adr;
      rd_dq <= next_rd_dq;
      rd_fl <= next_rd_fl;
      oe <= next_oe;
      done <= next_done;
    end
  end

  // Stage beats; commit only after the
  always_ff @(posedge clk_sys_i) begin
    if (state == DLIM_WR && rise) begin
      for (int l = 0; l < LANES; l++) begin
        stage[beat][l] <= wr_byte[l*LW +: LW];
        keep[beat][l] <= wr_keep[l];
      end
    end
    if (state == DLIM_COMMIT && !(crc_en_i && mask_en && !ok_s2)) begin
      for (int b = 0; b < dlim_pkg::BEATS; b++) begin
        for (int l = 0; l < LANES; l++) begin
          if (keep[b][l]) begin
            mem[adr][b][l] <= stage[b][l];
          end
        end
      end
    end
  end

  // Outputs
  assign lane.mem_dq = rd_dq;
  assign lane.mem_flag_n = rd_fl;
  assign lane.mem_oe = oe;
  assign persistent_crc_o = persist;
  assign wr_done_o = done;
  assign peek_o = raw_rd;
endmodule

// ==== src/dlim_pkg.sv ====
// Package: shared constants for the lane inversion and write mask codec.
// Assumes: both ends and the carrier interface compile after this file.
package dlim_pkg;
  // ****************************************
  // Burst and lane geometry
  // ****************************************
  localparam int BEATS = 8;
  localparam int BEAT_W = 3;
  localparam int LANE_W = 8;
  localparam int ZERO_LIMIT = 4;
  localparam logic [BEAT_W-1:0] LAST_BEAT = 3'h7;
  // ****************************************
  // Data lane organisations
  // ****************************************
  localparam int ORG_X4 = 4;
  localparam int ORG_X8 = 8;
  localparam int ORG_X16 = 16;
  // ****************************************
  // Mode bit positions in the mode words
  // ****************************************
  localparam int MR5_WIDTH = 13;
  localparam int MR1_WIDTH = 12;
  localparam int MASK_EN_BIT = 10;
  localparam int WINV_EN_BIT = 11;
  localparam int RINV_EN_BIT = 12;
  localparam int TERM_EN_BIT = 11;
  // ****************************************
  // Link clock divider for the controller
  // ****************************************
  localparam int LINK_HALF_DIV = 8;
  localparam int DIV_W = 4;
endpackage
